// [dtm_map.svh]
`ifndef DTM_MAP_SVH
`define DTM_MAP_SVH

// ==================================================
// register offsets on the 8-bit register port
`define DTM_OFF_MODE      8'h89
`define DTM_OFF_T0_LOW    8'h8A
`define DTM_OFF_T1_LOW    8'h8B
`define DTM_OFF_T0_HIGH   8'h8C
`define DTM_OFF_T1_HIGH   8'h8D

// ==================================================
// timer_mode_control field positions
`define DTM_T1_GATE_BIT   7
`define DTM_T1_SRC_BIT    6
`define DTM_T1_MODE_HI    5
`define DTM_T1_MODE_LO    4
`define DTM_T0_GATE_BIT   3
`define DTM_T0_SRC_BIT    2
`define DTM_T0_MODE_HI    1
`define DTM_T0_MODE_LO    0

// ==================================================
// reset values and timing counts
`define DTM_RST_BYTE      8'h00
`define DTM_RST_PINS      2'h3
`define DTM_UNMAPPED_READ 8'h00
`define DTM_PER_DIV       6
`define DTM_PRESC_MASK    5'h1F

`endif

// [dtm_pkg.sv]
package dtm_pkg;

  // ==================================================
  // per-timer mode, in the order of the two-bit field
  typedef enum logic [1:0] {
    DTM_MODE_13BIT,
    DTM_MODE_16BIT,
    DTM_MODE_RELOAD,
    DTM_MODE_SPLIT
  } dtm_mode_e;

  // ==================================================
  // whole register state of the top module
  typedef struct packed {
    logic [7:0] mode;      // timer_mode_control
    logic [7:0] t0_low;    // timer0_low_count
    logic [7:0] t0_high;   // timer0_high_count
    logic [7:0] t1_low;    // timer1_low_count
    logic [7:0] t1_high;   // timer1_high_count
    logic       t0_flag;   // timer0_overflow_flag
    logic       t1_flag;   // timer1_overflow_flag
    logic [7:0] rdata;     // read data, valid one cycle after the strobe
  } dtm_state_s;

  // ==================================================
  // count pin synchroniser state
  typedef struct packed {
    logic [1:0] meta;      // first stage, read only by stab
    logic [1:0] stab;      // second stage
    logic [1:0] prev;      // previous settled sample
    logic [1:0] fall;      // one-cycle falling edge pulse
  } dtm_sync_s;

endpackage

// [dtm_evt_if.sv]
`timescale 1ns/1ps

// ==================================================
// count events from the helpers to the timer core
interface dtm_evt_if;
  logic [1:0] fall;        // falling edge per count pin, one-cycle pulse
  logic       div_tick;    // divided-down clock tick, one-cycle pulse

  modport edge_src (output fall);
  modport div_src  (output div_tick);
  modport sink     (input fall, input div_tick);
endinterface

// [dtm_pin_sync.sv]
`timescale 1ns/1ps
`include "dtm_map.svh"

module dtm_pin_sync (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [1:0] pin_i,
  dtm_evt_if.edge_src     evt
);

  // ==================================================
  // state
  dtm_pkg::dtm_sync_s q, d;

  // two-stage sync, then high-then-low sample detects a fall
  always_comb begin
    d      = q;
    d.meta = pin_i;
    d.stab = q.meta;
    d.prev = q.stab;
    d.fall = q.prev & ~q.stab;
  end

  // idle level is high so reset never fakes an edge
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      q <= '{meta: `DTM_RST_PINS, stab: `DTM_RST_PINS, prev: `DTM_RST_PINS, fall: 2'h0};
    end else begin
      q <= d;
    end
  end

  assign evt.fall = q.fall;

endmodule

// [dtm_div.sv]
`timescale 1ns/1ps
`include "dtm_map.svh"

module dtm_div #(
  parameter int DIV_P = `DTM_PER_DIV
) (
  input  wire logic   mclk_i,
  input  wire logic   sys_rst_i,
  dtm_evt_if.div_src  evt
);

  localparam int W = (DIV_P > 1) ? $clog2(DIV_P) : 1;

  // a divide below two would tick every cycle and hide the divider
  if (DIV_P < 2) begin : g_bad_div
    $error("dtm_div: DIV_P must be at least 2");
  end

  // ==================================================
  // state
  typedef struct packed {
    logic [W-1:0] cnt;     // cycles since last tick
    logic         tick;    // registered tick
  } dtm_div_s;

  dtm_div_s q, d;

  // count 0..DIV_P-1 and pulse on the wrap
  always_comb begin
    d = q;
    if (q.cnt == W'(DIV_P - 1)) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt  = q.cnt + W'(1);
      d.tick = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      q <= '{cnt: '0, tick: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign evt.div_tick = q.tick;

endmodule

// [dtm_top.sv]
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "dtm_map.svh"

// Operation
// - timer1 ungated counts whenever its run set
// - timer1 gated needs pin one high, and run unless timer0 is in mode 3
// - timer1 source clear counts divided clock
// - timer1 source set counts pin one falls
// - timer0 ungated counts whenever its run set
// - timer0 gated needs pin zero high and run
// - timer0 source clear counts divided clock
// - timer0 source set counts pin zero falls
// - two-bit mode fields at 5:4 and 1:0
// - mode 0 is 5-bit prescaler plus byte
// - mode 1 is one 16-bit counter
// - timer1 mode 2 reloads low from high
// - timer0 mode 2 reloads low, high untouched
// - timer0 mode 3 low byte uses own controls
// - timer0 mode 3 high byte borrows timer1 run bit and flag
// - reset clears mode and all count bytes
// - split high byte counts divided clock only
// - timer1 mode 3 halts and holds count
// - wrap sets flag, vector acknowledge clears it
// - mode 0 ignores low byte upper bits
module dtm_top #(
  parameter int DIV_P = `DTM_PER_DIV
) (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       timer0_run_i,
  input  wire logic       timer1_run_i,
  input  wire logic       ext_irq_pin_zero_i,
  input  wire logic       ext_irq_pin_one_i,
  input  wire logic       count_input_pin_zero_i,
  input  wire logic       count_input_pin_one_i,
  input  wire logic       timer0_vector_ack_i,
  input  wire logic       timer1_vector_ack_i,
  output logic            timer0_overflow_flag_o,
  output logic            timer1_overflow_flag_o
);

  // ==================================================
  // helpers: pin edges and divided clock
  dtm_evt_if evt ();

  dtm_pin_sync u_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     ({count_input_pin_one_i, count_input_pin_zero_i}),
    .evt       (evt.edge_src)
  );

  dtm_div #(
    .DIV_P (DIV_P)
  ) u_div (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .evt       (evt.div_src)
  );

  // ==================================================
  // one counting step of a timer in modes 0..2; returns {wrap, high, low}
  function automatic logic [16:0] dtm_step(
    input dtm_pkg::dtm_mode_e m,
    input logic [7:0]         lo,
    input logic [7:0]         hi,
    input logic               inc
  );
    logic [5:0]  p;
    logic [8:0]  h;
    logic [16:0] w;
    p = {1'b0, lo[4:0]} + 6'h01;
    h = {1'b0, hi} + 9'h001;
    w = {1'b0, hi, lo} + 17'h00001;
    dtm_step = {1'b0, hi, lo};
    if (inc) begin
      case (m)
        dtm_pkg::DTM_MODE_13BIT: begin
          // upper three low-byte bits are left alone
          if (p[5]) begin
            dtm_step = {h[8], h[7:0], lo[7:5], p[4:0]};
          end else begin
            dtm_step = {1'b0, hi, lo[7:5], p[4:0]};
          end
        end
        dtm_pkg::DTM_MODE_16BIT: begin
          dtm_step = w;
        end
        dtm_pkg::DTM_MODE_RELOAD: begin
          // high byte is the reload value and never changes here
          if (lo == 8'hFF) begin
            dtm_step = {1'b1, hi, hi};
          end else begin
            dtm_step = {1'b0, hi, w[7:0]};
          end
        end
        default: begin
          dtm_step = {1'b0, hi, lo};
        end
      endcase
    end
  endfunction

  // ==================================================
  // state and decoded controls
  dtm_pkg::dtm_state_s q, d;

  dtm_pkg::dtm_mode_e t0_mode;   // timer 0 mode field
  dtm_pkg::dtm_mode_e t1_mode;   // timer 1 mode field
  logic       t0_en;             // timer 0 run/gate qualifier
  logic       t1_en;             // timer 1 run/gate qualifier
  logic       t0_tick;           // timer 0 selected source event
  logic       t1_tick;           // timer 1 selected source event
  logic       t0_inc;            // timer 0 advances this cycle
  logic       t1_inc;            // timer 1 advances this cycle
  logic       th0_inc;           // split high byte advances this cycle
  logic       split;             // timer 0 in mode 3
  logic       t0_wrap;           // timer 0 (or its low byte) wrapped
  logic       t1_wrap;           // timer 1 (or split high byte) wrapped
  logic [16:0] t0_nxt;           // timer 0 step result
  logic [16:0] t1_nxt;           // timer 1 step result
  logic [8:0]  lo0_sum;          // split low byte plus one
  logic [8:0]  hi0_sum;          // split high byte plus one
  logic        wr_mode;          // write strobes per register
  logic        wr_t0l;
  logic        wr_t0h;
  logic        wr_t1l;
  logic        wr_t1h;

  // write decode at the printed offsets
  assign wr_mode = reg_wr_i && (reg_addr_i == `DTM_OFF_MODE);
  assign wr_t0l  = reg_wr_i && (reg_addr_i == `DTM_OFF_T0_LOW);
  assign wr_t0h  = reg_wr_i && (reg_addr_i == `DTM_OFF_T0_HIGH);
  assign wr_t1l  = reg_wr_i && (reg_addr_i == `DTM_OFF_T1_LOW);
  assign wr_t1h  = reg_wr_i && (reg_addr_i == `DTM_OFF_T1_HIGH);

  // ==================================================
  // count qualification
  always_comb begin
    // mode fields
    t0_mode = dtm_pkg::dtm_mode_e'(q.mode[`DTM_T0_MODE_HI:`DTM_T0_MODE_LO]);
    t1_mode = dtm_pkg::dtm_mode_e'(q.mode[`DTM_T1_MODE_HI:`DTM_T1_MODE_LO]);
    split   = (t0_mode == dtm_pkg::DTM_MODE_SPLIT);
    // run alone, or run with the pin high when gated
    t0_en = timer0_run_i && (!q.mode[`DTM_T0_GATE_BIT] || ext_irq_pin_zero_i);
    // timer 1 loses its run bit to the split high byte; the mode field then starts and stops it
    if (split) begin
      t1_en = !q.mode[`DTM_T1_GATE_BIT] || ext_irq_pin_one_i;
    end else begin
      t1_en = timer1_run_i && (!q.mode[`DTM_T1_GATE_BIT] || ext_irq_pin_one_i);
    end
    // source select: divided clock or pin falls
    t0_tick = q.mode[`DTM_T0_SRC_BIT] ? evt.fall[0] : evt.div_tick;
    t1_tick = q.mode[`DTM_T1_SRC_BIT] ? evt.fall[1] : evt.div_tick;
    t0_inc  = t0_en && t0_tick;
    t1_inc  = t1_en && t1_tick;
    // split high byte is a pure timer on timer 1's run bit
    th0_inc = split && timer1_run_i && evt.div_tick;
  end

  // ==================================================
  // next state
  always_comb begin
    d       = q;
    t0_nxt  = dtm_step(t0_mode, q.t0_low, q.t0_high, t0_inc);
    t1_nxt  = dtm_step(t1_mode, q.t1_low, q.t1_high, t1_inc);
    lo0_sum = {1'b0, q.t0_low} + 9'h001;
    hi0_sum = {1'b0, q.t0_high} + 9'h001;
    t0_wrap = 1'b0;
    t1_wrap = 1'b0;

    // timer 0 count bytes
    if (split) begin
      // two independent 8-bit counters
      if (t0_inc) begin
        d.t0_low = lo0_sum[7:0];
        t0_wrap  = lo0_sum[8];
      end
      if (th0_inc) begin
        d.t0_high = hi0_sum[7:0];
      end
    end else begin
      d.t0_low  = t0_nxt[7:0];
      d.t0_high = t0_nxt[15:8];
      t0_wrap   = t0_nxt[16];
    end

    // timer 1 count bytes
    d.t1_low  = t1_nxt[7:0];
    d.t1_high = t1_nxt[15:8];

    // flag 1 belongs to the split high byte while timer 0 is in mode 3
    if (split) begin
      t1_wrap = th0_inc && hi0_sum[8];
    end else begin
      t1_wrap = t1_nxt[16];
    end

    // a software write overrides a same-cycle increment of that byte
    if (wr_t0l) begin
      d.t0_low = reg_wdata_i;
    end
    if (wr_t0h) begin
      d.t0_high = reg_wdata_i;
    end
    if (wr_t1l) begin
      d.t1_low = reg_wdata_i;
    end
    if (wr_t1h) begin
      d.t1_high = reg_wdata_i;
    end
    if (wr_mode) begin
      d.mode = reg_wdata_i;
    end

    // flags: a wrap in the acknowledge cycle keeps the flag set
    if (t0_wrap) begin
      d.t0_flag = 1'b1;
    end else if (timer0_vector_ack_i) begin
      d.t0_flag = 1'b0;
    end
    if (t1_wrap) begin
      d.t1_flag = 1'b1;
    end else if (timer1_vector_ack_i) begin
      d.t1_flag = 1'b0;
    end

    // read data for the next cycle only; zero otherwise
    d.rdata = `DTM_UNMAPPED_READ;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `DTM_OFF_MODE: begin
          d.rdata = q.mode;
        end
        `DTM_OFF_T0_LOW: begin
          d.rdata = q.t0_low;
        end
        `DTM_OFF_T0_HIGH: begin
          d.rdata = q.t0_high;
        end
        `DTM_OFF_T1_LOW: begin
          d.rdata = q.t1_low;
        end
        `DTM_OFF_T1_HIGH: begin
          d.rdata = q.t1_high;
        end
        default: begin
          d.rdata = `DTM_UNMAPPED_READ;
        end
      endcase
    end
  end

  // ==================================================
  // state register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      q <= '{mode: `DTM_RST_BYTE, t0_low: `DTM_RST_BYTE, t0_high: `DTM_RST_BYTE,
             t1_low: `DTM_RST_BYTE, t1_high: `DTM_RST_BYTE, t0_flag: 1'b0,
             t1_flag: 1'b0, rdata: `DTM_RST_BYTE};
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state flops
  assign reg_rdata_o            = q.rdata;
  assign timer0_overflow_flag_o = q.t0_flag;
  assign timer1_overflow_flag_o = q.t1_flag;

  // ==================================================
  // assertions
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic any_wr;  // any write this cycle
  assign any_wr = reg_wr_i;

  AST_RESET_CLEARS: assert property (disable iff (1'b0) sys_rst_i |=>
    (q.mode == 8'h00) && (q.t0_low == 8'h00) && (q.t0_high == 8'h00) &&
    (q.t1_low == 8'h00) && (q.t1_high == 8'h00))
    else $error("reset left a count byte or mode nonzero");

  AST_T1_HOLD: assert property ((t1_mode == dtm_pkg::DTM_MODE_SPLIT) && !wr_t1l && !wr_t1h |=>
    $stable(q.t1_low) && $stable(q.t1_high))
    else $error("timer 1 moved in hold mode");

  AST_T0_GATED: assert property (q.mode[3] && !ext_irq_pin_zero_i && !split && !any_wr |=>
    $stable(q.t0_low) && $stable(q.t0_high))
    else $error("timer 0 counted with its gate pin low");

  AST_T0_NORUN: assert property (!timer0_run_i && !split && !any_wr |=>
    $stable(q.t0_low) && $stable(q.t0_high))
    else $error("timer 0 counted with run clear");

  AST_T1_NORUN: assert property (!timer1_run_i && !split && !any_wr |=>
    $stable(q.t1_low) && $stable(q.t1_high))
    else $error("timer 1 counted with run clear");

  AST_T0_TIMER: assert property (!q.mode[`DTM_T0_SRC_BIT] && !evt.div_tick && !any_wr |=>
    $stable(q.t0_low) && $stable(q.t0_high))
    else $error("timer 0 counted without a divided tick");

  AST_T0_RELOAD: assert property ((t0_mode == dtm_pkg::DTM_MODE_RELOAD) && t0_inc &&
    (q.t0_low == 8'hFF) && !any_wr |=> (q.t0_low == $past(q.t0_high)) && $stable(q.t0_high) && q.t0_flag)
    else $error("timer 0 reload failed");

  AST_T1_WIDE: assert property ((t1_mode == dtm_pkg::DTM_MODE_16BIT) && t1_inc && !any_wr |=>
    ({q.t1_high, q.t1_low} == 16'($past({q.t1_high, q.t1_low}) + 16'h0001)))
    else $error("timer 1 16-bit step wrong");

  AST_T0_PRESC: assert property ((t0_mode == dtm_pkg::DTM_MODE_13BIT) && t0_inc &&
    (q.t0_low[4:0] == 5'h1F) && !any_wr |=> (q.t0_high == 8'($past(q.t0_high) + 8'h01)) &&
    (q.t0_low[4:0] == 5'h00) && $stable(q.t0_low[7:5]))
    else $error("timer 0 prescaler carry wrong");

  AST_T0_EXT: assert property (q.mode[2] && !evt.fall[0] && !split && !any_wr |=>
    $stable(q.t0_low) && $stable(q.t0_high))
    else $error("timer 0 counted without a pin fall");

  AST_TH0_SPLIT: assert property (split && timer1_run_i && evt.div_tick && !any_wr |=>
    (q.t0_high == 8'($past(q.t0_high) + 8'h01)))
    else $error("split high byte did not advance");

  AST_FLAG_WINS: assert property (t0_wrap && timer0_vector_ack_i |=> q.t0_flag)
    else $error("timer 0 wrap lost to acknowledge");

  AST_READ_MODE: assert property (reg_rd_i && (reg_addr_i == `DTM_OFF_MODE) && !wr_mode |=>
    (reg_rdata_o == $past(q.mode)) ##1 (reg_rdata_o == 8'h00 || reg_rd_i || $past(reg_rd_i)))
    else $error("mode read data wrong");

  COV_RELOAD: cover property ((t0_mode == dtm_pkg::DTM_MODE_RELOAD) && t0_wrap);
  COV_SPLIT: cover property (split && t1_wrap);
  COV_EXT: cover property (q.mode[6] && t1_inc);
  COV_ACK_RACE: cover property (t1_wrap && timer1_vector_ack_i);

endmodule

// [dtm_pin_model.sv]
`timescale 1ns/1ps

// ==================================================
// far-side pins: count inputs idle high on pull-ups, gating pins as asked
module dtm_pin_model (
  input  wire logic       mclk_i,
  input  wire logic [1:0] fall_req_i,   // one-cycle request for one falling edge
  input  wire logic [1:0] gate_lvl_i,   // level wanted on the gating pins
  output logic      [1:0] count_pin_o,  // external count pins
  output logic      [1:0] irq_pin_o     // gating pins
);
  int unsigned hold_q [2] = '{0, 0};    // cycles left of the current pulse
  logic [1:0]  pin_q = 2'h3;            // count pin levels, pulled up until the first pulse

  // gating pins follow the bench level directly
  assign irq_pin_o = gate_lvl_i;

  // one process owns the count pin levels
  assign count_pin_o = pin_q;

  // each pulse is 3 cycles low then at least 4 high, so both levels outlast the
  // two-flop synchroniser; requests during a pulse are dropped
  always @(posedge mclk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (hold_q[i] == 0 && fall_req_i[i]) begin
        hold_q[i]      <= 6;
        pin_q[i]       <= 1'b0;
      end else if (hold_q[i] != 0) begin
        hold_q[i]      <= hold_q[i] - 1;
        pin_q[i]       <= (hold_q[i] > 4) ? 1'b0 : 1'b1;
      end
    end
  end
endmodule

// [test_dual_timer_mode_control.sv]
`timescale 1ns/1ps
`include "dtm_map.svh"

module test_dual_timer_mode_control;
  localparam int DIV = 2;              // short divider keeps the run brief

  // ==================================================
  // one table row: setup, run window and expected outcome
  typedef struct {
    logic [7:0]  mode;                 // timer_mode_control value
    logic [31:0] init;                 // {t1h, t1l, t0h, t0l}
    logic [1:0]  run;                  // {timer1_run, timer0_run}
    logic [1:0]  gate;                 // gating pin levels
    int          k;                    // divided ticks in the window
    logic [31:0] exp;                  // counts afterwards, same order
    logic [1:0]  flg;                  // {flag1, flag0}
  } dtm_row_s;

  logic       mclk_i;
  logic       sys_rst_i;
  logic [7:0] reg_addr, reg_wdata, rdata, d;
  logic       reg_wr, reg_rd, run0, run1, flag0, flag1;
  logic [1:0] ack, fall_req, gate_lvl, cpin, ipin;
  int         failures  = 0;           // mismatches seen
  int         cmp_count = 0;           // comparisons made
  dtm_row_s   rows [9];
  logic [7:0] offs [4] = '{`DTM_OFF_T0_LOW, `DTM_OFF_T0_HIGH, `DTM_OFF_T1_LOW, `DTM_OFF_T1_HIGH};

  // ==================================================
  // clock, design and far-side model
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  dtm_top #(.DIV_P(DIV)) u_dut (
    .mclk_i                 (mclk_i),
    .sys_rst_i              (sys_rst_i),
    .reg_addr_i             (reg_addr),
    .reg_wdata_i            (reg_wdata),
    .reg_wr_i               (reg_wr),
    .reg_rd_i               (reg_rd),
    .reg_rdata_o            (rdata),
    .timer0_run_i           (run0),
    .timer1_run_i           (run1),
    .ext_irq_pin_zero_i     (ipin[0]),
    .ext_irq_pin_one_i      (ipin[1]),
    .count_input_pin_zero_i (cpin[0]),
    .count_input_pin_one_i  (cpin[1]),
    .timer0_vector_ack_i    (ack[0]),
    .timer1_vector_ack_i    (ack[1]),
    .timer0_overflow_flag_o (flag0),
    .timer1_overflow_flag_o (flag1)
  );

  dtm_pin_model u_pins (
    .mclk_i      (mclk_i),
    .fall_req_i  (fall_req),
    .gate_lvl_i  (gate_lvl),
    .count_pin_o (cpin),
    .irq_pin_o   (ipin)
  );

  // ==================================================
  // bus cycles and comparison
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk_i);
    reg_wr    <= 1'b0;
  endtask

  // data are taken in the one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk_i);
    reg_rd   <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // run bits high for exactly k divided periods, then settle
  task automatic run_win(input logic [1:0] r, input int k);
    @(posedge mclk_i);
    run0 <= r[0];
    run1 <= r[1];
    repeat (k * DIV) @(posedge mclk_i);
    run0 <= 1'b0;
    run1 <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask

  task automatic chk_cleared();
    for (int i = 0; i < 5; i++) begin
      rd(8'h89 + 8'(i), d);
      chk(d, `DTM_RST_BYTE);
    end
    chk({6'h00, flag1, flag0}, 8'h00);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==================================================
  // watchdog, well beyond the expected few hundred cycles
  initial begin
    #200000;
    failures++;
    end_of_test();
  end

  // ==================================================
  // main sequence
  initial begin
    rows[0] = '{8'h11, 32'hFF_FE_00_FF, 2'h3, 2'h0, 3, 32'h00_01_01_02, 2'h2};
    rows[1] = '{8'h00, 32'hFF_1F_05_FE, 2'h3, 2'h0, 3, 32'h00_02_06_E1, 2'h2};
    rows[2] = '{8'h22, 32'h10_FF_80_FE, 2'h3, 2'h0, 3, 32'h10_12_80_81, 2'h3};
    rows[3] = '{8'h33, 32'hAA_55_FE_FF, 2'h3, 2'h0, 3, 32'hAA_55_01_02, 2'h3};
    rows[4] = '{8'h88, 32'h00_00_00_00, 2'h3, 2'h0, 3, 32'h00_00_00_00, 2'h0};
    rows[5] = '{8'h99, 32'h00_FF_00_FF, 2'h3, 2'h3, 2, 32'h01_01_01_01, 2'h0};
    rows[6] = '{8'h11, 32'h12_34_56_78, 2'h0, 2'h0, 4, 32'h12_34_56_78, 2'h0};
    rows[7] = '{8'h11, 32'h00_00_00_00, 2'h1, 2'h0, 2, 32'h00_00_00_02, 2'h0};
    rows[8] = '{8'h83, 32'h00_00_00_00, 2'h2, 2'h0, 2, 32'h00_00_02_00, 2'h0};
    // time-zero values, count pins idle high, gating pins low
    sys_rst_i = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    run0      = 1'b0;
    run1      = 1'b0;
    ack       = 2'h0;
    fall_req  = 2'h0;
    gate_lvl  = 2'h0;
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    chk_cleared();
    // table rows: modes, gating, run bits, wraps and flags
    foreach (rows[r]) begin
      wr(`DTM_OFF_MODE, rows[r].mode);
      for (int i = 0; i < 4; i++) wr(offs[i], rows[r].init[8*i +: 8]);
      @(posedge mclk_i);
      gate_lvl <= rows[r].gate;
      run_win(rows[r].run, rows[r].k);
      for (int i = 0; i < 4; i++) begin
        rd(offs[i], d);
        chk(d, rows[r].exp[8*i +: 8]);
      end
      chk({6'h00, flag1, flag0}, {6'h00, rows[r].flg});
      @(posedge mclk_i);
      ack <= 2'h3;
      @(posedge mclk_i);
      ack <= 2'h0;
      @(posedge mclk_i);
      #1 chk({6'h00, flag1, flag0}, 8'h00);
    end
    // unmapped write ignored, unmapped read zero, data stand one cycle
    wr(8'h8E, 8'hFF);
    rd(8'h88, d);
    chk(d, `DTM_UNMAPPED_READ);
    wr(`DTM_OFF_MODE, 8'hA5);
    rd(`DTM_OFF_MODE, d);
    chk(d, 8'hA5);
    @(posedge mclk_i);
    #1 chk(rdata, 8'h00);
    // count pins as sources: only the three falls count, not the divider
    wr(`DTM_OFF_MODE, 8'h55);
    for (int i = 0; i < 4; i++) wr(offs[i], 8'h00);
    @(posedge mclk_i);
    run0 <= 1'b1;
    run1 <= 1'b1;
    repeat (3) begin
      @(posedge mclk_i);
      fall_req <= 2'h3;
      @(posedge mclk_i);
      fall_req <= 2'h0;
      repeat (8) @(posedge mclk_i);
    end
    run0 <= 1'b0;
    run1 <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(offs[i], d);
      chk(d, (i % 2 == 0) ? 8'h03 : 8'h00);
    end
    // reset in mid-run clears everything again, set flags included
    wr(`DTM_OFF_MODE, 8'h11);
    for (int i = 0; i < 4; i++) wr(offs[i], 8'hFF);
    @(posedge mclk_i);
    run0 <= 1'b1;
    run1 <= 1'b1;
    repeat (10) @(posedge mclk_i);
    #1 chk({6'h00, flag1, flag0}, 8'h03);
    sys_rst_i <= 1'b1;
    run0      <= 1'b0;
    run1      <= 1'b0;
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    chk_cleared();
    end_of_test();
  end
endmodule
